// [smc_consts.svh]
// constants for the sleep-mode controller: codes, counts, bit positions
// assumes a single 250 MHz system clock and plain port control bits
//
// Contract
// - sleep only when entry permit set
// - code 000 idle stops core and flash
// - idle wakes on any enabled interrupt
// - code 001 noise mode stops peripheral clock
// - noise entry starts one conversion if enabled
// - noise mode wakes only on listed sources
// - code 010 power-down stops all generated clocks
// - power-down wakes only on listed sources
// - deep modes: external lines wake level only
// - level gone before start-up: wake, no interrupt
// - power-down wake waits the start-up delay
// - code 011 power-save keeps second timer
// - timer wake needs its mask and global
// - power-save stops unused timer clock sources
// - halt four cycles, handler, then resume
// - sleep leaves registers and memory untouched
// - reset while asleep restarts from vector
// - detector off at entry, on at wake; code keeps it off until start-up ends
// - detector off extends wake to 60us
// - detector-sleep-off one disables, resets zero
// - detector shutdown only in deep modes
// - detector-sleep-off written via timed sequence
// - codes 110/111 standby, oscillator on, six
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_NOISE 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_CLK_PERIOD_NS 4
`define SMC_BOD_WAKE_NS 60000
`define SMC_BOD_WAKE_CYC (`SMC_BOD_WAKE_NS / `SMC_CLK_PERIOD_NS)
`define SMC_STARTUP_CYC 16384
`define SMC_STBY_CYC 6
`define SMC_HALT_CYC 4
`define SMC_CHG_WIN_CYC 3'h4
`define SMC_NSYNC 8
`define SMC_S_PIN 2
`define SMC_S_TWI 3
`define SMC_S_WDT 4
`define SMC_S_ATMR 5
`define SMC_S_T2OVF 6
`define SMC_S_T2CMP 7
`endif

// [smc_pkg.sv]
// types for the sleep-mode controller
// assumes the constants header is included by the design file
package smc_pkg;
    typedef enum logic [1:0] {SMC_RUN, SMC_SLEEP, SMC_START, SMC_HALT}
        smc_state_e;
    typedef logic [2:0] smc_mode_t;
    typedef logic [15:0] smc_cnt_t;
endpackage : smc_pkg

// [smc_sleep_ctrl.sv]
// sleep-mode controller: clock gating, wake selection, wake-up timing
// assumes core, converter and nvm strobes are on CLK_IN; pins are async
`timescale 1ns/1ns
`default_nettype none
`include "smc_consts.svh"
module smc_sleep_ctrl
    import smc_pkg::*;
#(
    parameter int STARTUP_CYCLES = `SMC_STARTUP_CYC, // clock restart
    parameter int BOD_WAKE_CYCLES = `SMC_BOD_WAKE_CYC // detector settle
) (
    input wire logic CLK_IN, // system clock
    input wire logic RESETN_IN, // async reset, active low
    input wire logic SLEEP_EXEC_IN, // core executes sleep, pulse
    input wire logic SLEEP_ENTRY_PERMIT_IN, // permit bit
    input wire logic [2:0] LOW_POWER_STATE_CHOICE_IN, // mode code
    input wire logic CORE_CTRL_WR_IN, // control write strobe
    input wire logic [1:0] CORE_CTRL_WDATA_IN, // {sleep_off, chg_en}
    input wire logic IRQ_PENDING_IN, // any enabled interrupt
    input wire logic [1:0] EXT_IRQ_LINE_IN, // external lines, pins
    input wire logic [1:0] EXT_IRQ_LEVEL_MODE_IN, // 1 = level trigger
    input wire logic PIN_CHANGE_IRQ_IN, // pin change, async
    input wire logic TWO_WIRE_MATCH_IN, // address match, async
    input wire logic WATCHDOG_EVENT_IN, // watchdog irq, async
    input wire logic ASYNC_TIMER_IRQ_IN, // async timer irq
    input wire logic TIMER2_OVF_IN, // second timer overflow
    input wire logic TIMER2_CMP_IN, // second timer compare
    input wire logic [1:0] TIMER2_IRQ_MASK_IN, // {cmp, ovf} enables
    input wire logic GLOBAL_IRQ_EN_IN, // global interrupt enable
    input wire logic TIMER2_ASYNC_IN, // timer on async clock
    input wire logic TIMER2_SYNC_IN, // timer on sync clock
    input wire logic CONV_ENABLED_IN, // converter enabled
    input wire logic CONV_DONE_IN, // conversion complete
    input wire logic NVM_READY_IN, // store-program/nvm ready
    output logic CORE_CLK_EN_OUT, // core clock domain
    output logic PROG_MEM_CLK_EN_OUT, // program memory clock
    output logic PERIPH_CLK_EN_OUT, // peripheral clock
    output logic CONV_CLK_EN_OUT, // converter clock
    output logic ASYNC_CLK_EN_OUT, // async timer clock
    output logic MAIN_OSC_EN_OUT, // main clock source
    output logic TIMER_OSC_EN_OUT, // timer oscillator
    output logic TIMER2_SYNC_CLK_EN_OUT, // sync clock to timer only
    output logic CONV_START_OUT, // start conversion, pulse
    output logic DETECTOR_EN_OUT, // supply drop detector on
    output logic DETECTOR_SLEEP_OFF_OUT, // stored sleep-off bit
    output logic ASLEEP_OUT, // in sleep
    output logic IRQ_SERVICE_OUT, // run handler, pulse
    output logic SLEEP_IGNORED_OUT // sleep taken as nop, pulse
);

////////////////////////////////////////////////////////////////////////
// mode decoding

    function automatic logic is_deep(input smc_mode_t m);
        is_deep = (m == `SMC_MODE_PDOWN) || (m == `SMC_MODE_PSAVE) ||
                  (m == `SMC_MODE_STBY) || (m == `SMC_MODE_XSTBY);
    endfunction : is_deep

    function automatic logic keeps_t2(input smc_mode_t m);
        keeps_t2 = (m == `SMC_MODE_PSAVE) || (m == `SMC_MODE_XSTBY);
    endfunction : keeps_t2

    function automatic logic is_valid(input smc_mode_t m);
        is_valid = (m == `SMC_MODE_IDLE) || (m == `SMC_MODE_NOISE) ||
                   is_deep(m);
    endfunction : is_valid

////////////////////////////////////////////////////////////////////////
// pin synchronisers, two flops each

    logic [`SMC_NSYNC-1:0] async_raw;
    logic [`SMC_NSYNC-1:0] sync_w;
    assign async_raw = {TIMER2_CMP_IN, TIMER2_OVF_IN, ASYNC_TIMER_IRQ_IN,
                        WATCHDOG_EVENT_IN, TWO_WIRE_MATCH_IN,
                        PIN_CHANGE_IRQ_IN, EXT_IRQ_LINE_IN};

    for (genvar i = 0; i < `SMC_NSYNC; i++) begin : g_sync
        logic meta_q;
        logic sync_q;
        // only sync_q is read; meta_q may be metastable
        always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= async_raw[i];
                sync_q <= meta_q;
            end
        end
        assign sync_w[i] = sync_q;
    end

////////////////////////////////////////////////////////////////////////
// wake source selection per mode

    smc_state_e st_q, st_d;
    smc_mode_t mode_q, mode_d;
    smc_cnt_t cnt_q, cnt_d;
    logic detector_sleep_off_q, detector_sleep_off_d;
    logic irq_q, irq_d;
    logic dso_q;
    logic [2:0] win_q;

    // edge-triggered external lines never reach the deep wake terms
    wire lvl_wake = |(sync_w[1:0] & EXT_IRQ_LEVEL_MODE_IN);
    wire base_wake = lvl_wake | sync_w[`SMC_S_PIN] |
                     sync_w[`SMC_S_TWI] | sync_w[`SMC_S_WDT];
    wire t2_wake = GLOBAL_IRQ_EN_IN &
        |({sync_w[`SMC_S_T2CMP], sync_w[`SMC_S_T2OVF]} &
          TIMER2_IRQ_MASK_IN);
    wire noise_wake = base_wake | CONV_DONE_IN | NVM_READY_IN |
                      sync_w[`SMC_S_ATMR];
    wire idle_wake = IRQ_PENDING_IN | lvl_wake;
    wire deep_wake = base_wake | (keeps_t2(mode_q) & t2_wake);
    wire wake_hit = (mode_q == `SMC_MODE_IDLE) ? idle_wake :
                    (mode_q == `SMC_MODE_NOISE) ? noise_wake :
                    deep_wake;
    wire sleep_go = SLEEP_EXEC_IN & SLEEP_ENTRY_PERMIT_IN &
                    is_valid(LOW_POWER_STATE_CHOICE_IN);
    wire standby = (mode_q == `SMC_MODE_STBY) ||
                   (mode_q == `SMC_MODE_XSTBY);

    // restart wait: oscillator start-up, shorter when it kept running
    wire [15:0] osc_wait = standby ? 16'(`SMC_STBY_CYC) :
        16'(STARTUP_CYCLES);
    wire [15:0] bod_wait = 16'(BOD_WAKE_CYCLES);
    wire [15:0] wake_wait = (detector_sleep_off_q && bod_wait > osc_wait) ?
        bod_wait : osc_wait;

////////////////////////////////////////////////////////////////////////
// sequencer next state

    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        detector_sleep_off_d = detector_sleep_off_q;
        irq_d = irq_q;
        case (st_q)
            SMC_RUN: begin
                if (sleep_go) begin
                    st_d = SMC_SLEEP;
                    mode_d = LOW_POWER_STATE_CHOICE_IN;
                    detector_sleep_off_d = dso_q & is_deep(mode_d);
                end
            end
            SMC_SLEEP: begin
                if (wake_hit) begin
                    // pulse sources are latched unless a level wakes in the same cycle; levels re-checked later
                    irq_d = wake_hit & ~lvl_wake;
                    if (is_deep(mode_q)) begin
                        st_d = SMC_START;
                        cnt_d = wake_wait - 16'h0001;
                    end else begin
                        st_d = SMC_HALT;
                        cnt_d = 16'(`SMC_HALT_CYC - 1);
                    end
                end
            end
            SMC_START: begin
                if (cnt_q == 16'h0000) begin
                    st_d = SMC_HALT;
                    cnt_d = 16'(`SMC_HALT_CYC - 1);
                    detector_sleep_off_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            SMC_HALT: begin
                detector_sleep_off_d = 1'b0;
                if (cnt_q == 16'h0000) begin
                    st_d = SMC_RUN;
                    irq_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: st_d = SMC_RUN;
        endcase
    end

////////////////////////////////////////////////////////////////////////
// clock enables from the next state, so outputs track st_q

    wire nrun = (st_d == SMC_RUN);
    wire nslp = (st_d == SMC_SLEEP);
    wire nstart = (st_d == SMC_START);
    wire m_idle = (mode_d == `SMC_MODE_IDLE);
    wire m_noise = (mode_d == `SMC_MODE_NOISE);
    wire m_t2 = keeps_t2(mode_d);
    wire m_stby = (mode_d == `SMC_MODE_STBY) || (mode_d == `SMC_MODE_XSTBY);
    // core and flash only stop; no state is cleared by sleeping
    wire core_en_d = nrun;
    wire periph_en_d = nrun | (st_d == SMC_HALT) |
                       (nslp & m_idle);
    wire conv_en_d = periph_en_d | (nslp & m_noise);
    // the timer keeps only the clock that it really uses
    wire async_en_d = ~nslp | m_idle | m_noise |
                      (m_t2 & TIMER2_ASYNC_IN);
    wire main_en_d = ~nslp | m_idle | m_noise | m_stby |
                     (m_t2 & TIMER2_SYNC_IN);
    wire tosc_en_d = TIMER2_ASYNC_IN &
                     (~nslp | m_idle | m_noise | m_t2);
    wire t2sync_en_d = TIMER2_SYNC_IN & (~nslp | m_idle | m_t2);
    wire conv_go_d = (st_q == SMC_RUN) & sleep_go &
                     (LOW_POWER_STATE_CHOICE_IN == `SMC_MODE_NOISE) &
                     CONV_ENABLED_IN;
    // a level that vanished before the end wakes without an interrupt
    wire irq_go_d = (st_q == SMC_HALT) & nrun &
                    (irq_q | lvl_wake);
    wire nop_d = (st_q == SMC_RUN) & SLEEP_EXEC_IN & ~sleep_go;
    wire det_en_d = ~((nslp | nstart) & detector_sleep_off_d);

////////////////////////////////////////////////////////////////////////
// state and output registers; reset returns to run at the vector

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q <= SMC_RUN;
            mode_q <= `SMC_MODE_IDLE;
            cnt_q <= 16'h0000;
            detector_sleep_off_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            detector_sleep_off_q <= detector_sleep_off_d;
            irq_q <= irq_d;
        end
    end

    // output flops; enables reset to the running configuration
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            {CORE_CLK_EN_OUT, PROG_MEM_CLK_EN_OUT} <= 2'h3;
            {PERIPH_CLK_EN_OUT, CONV_CLK_EN_OUT} <= 2'h3;
            {ASYNC_CLK_EN_OUT, MAIN_OSC_EN_OUT} <= 2'h3;
            {TIMER_OSC_EN_OUT, TIMER2_SYNC_CLK_EN_OUT} <= 2'h0;
            {CONV_START_OUT, DETECTOR_EN_OUT, ASLEEP_OUT} <= 3'h2;
            {IRQ_SERVICE_OUT, SLEEP_IGNORED_OUT} <= 2'h0;
        end else begin
            {CORE_CLK_EN_OUT, PROG_MEM_CLK_EN_OUT} <= {2{core_en_d}};
            {PERIPH_CLK_EN_OUT, CONV_CLK_EN_OUT} <= {periph_en_d, conv_en_d};
            {ASYNC_CLK_EN_OUT, MAIN_OSC_EN_OUT} <= {async_en_d, main_en_d};
            {TIMER_OSC_EN_OUT, TIMER2_SYNC_CLK_EN_OUT} <=
                {tosc_en_d, t2sync_en_d};
            {CONV_START_OUT, DETECTOR_EN_OUT, ASLEEP_OUT} <=
                {conv_go_d, det_en_d, nslp};
            {IRQ_SERVICE_OUT, SLEEP_IGNORED_OUT} <= {irq_go_d, nop_d};
        end
    end

////////////////////////////////////////////////////////////////////////
// detector-sleep-off bit behind a four-cycle change window

    wire open_w = CORE_CTRL_WR_IN & (CORE_CTRL_WDATA_IN == 2'h3);
    wire set_w = CORE_CTRL_WR_IN & ~CORE_CTRL_WDATA_IN[0] &
                 (win_q != 3'h0);
    // a rewrite of the enable inside the window does not extend it
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            win_q <= 3'h0;
            dso_q <= 1'b0;
        end else if (set_w) begin
            win_q <= 3'h0;
            dso_q <= CORE_CTRL_WDATA_IN[1];
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
        end else if (open_w) begin
            win_q <= `SMC_CHG_WIN_CYC;
        end
    end
    assign DETECTOR_SLEEP_OFF_OUT = dso_q;

////////////////////////////////////////////////////////////////////////
// checks

    sequence s_halt4;
        (st_q == SMC_HALT) [*4] ##1 (st_q == SMC_RUN);
    endsequence
    sequence s_stby6;
        (st_q == SMC_START) [*6] ##1 s_halt4;
    endsequence

    chk_permit_entry: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (st_q == SMC_RUN && sleep_go)
        |=> ASLEEP_OUT && !CORE_CLK_EN_OUT)
        else $error("sleep not entered with permit");
    chk_nop_sleep: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (st_q == SMC_RUN && nop_d)
        |=> CORE_CLK_EN_OUT && SLEEP_IGNORED_OUT)
        else $error("sleep without permit gated clocks");
    chk_idle_clocks: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (ASLEEP_OUT && mode_q == `SMC_MODE_IDLE)
        |-> PERIPH_CLK_EN_OUT && !PROG_MEM_CLK_EN_OUT)
        else $error("idle clock set wrong");
    chk_pdown_clocks: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (ASLEEP_OUT && mode_q == `SMC_MODE_PDOWN)
        |-> !MAIN_OSC_EN_OUT && !CONV_CLK_EN_OUT)
        else $error("power-down left a clock on");
    chk_conv_start: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) $rose(ASLEEP_OUT) &&
        mode_q == `SMC_MODE_NOISE && $past(CONV_ENABLED_IN)
        |-> CONV_START_OUT)
        else $error("noise entry did not start conversion");
    chk_edge_only: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (st_q == SMC_SLEEP && is_deep(mode_q)
        && !deep_wake && IRQ_PENDING_IN) |=> st_q == SMC_SLEEP)
        else $error("deep sleep woke on edge interrupt");
    chk_t2_gate: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (st_q == SMC_SLEEP && keeps_t2(mode_q)
        && !base_wake && !GLOBAL_IRQ_EN_IN) |=> st_q == SMC_SLEEP)
        else $error("timer woke without global enable");
    chk_halt_four: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) $rose(st_q == SMC_HALT) |-> s_halt4)
        else $error("halt not four cycles");
    chk_stby_six: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) ($rose(st_q == SMC_START) && standby &&
        !detector_sleep_off_q) |-> s_stby6)
        else $error("standby wake not six cycles");
    chk_bod_off: assert property (@(posedge CLK_IN)
        disable iff (!RESETN_IN) (ASLEEP_OUT && (!is_deep(mode_q) ||
        !detector_sleep_off_q)) |-> DETECTOR_EN_OUT)
        else $error("detector off in wrong mode");

endmodule : smc_sleep_ctrl
`default_nettype wire

// [smc_dummy_end.sv]
// intentionally empty compile unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [smc_core_model.sv]
// core-side partner: sleep instruction and control-bit writes
// assumes one caller process and a free-running system clock
`timescale 1ns/1ns
`default_nettype none
module smc_core_model (
    input wire logic clk_in, // system clock
    output var logic sleep_exec_out, // sleep instruction pulse
    output var logic permit_out, // entry permit bit
    output var logic [2:0] mode_out, // mode code
    output var logic ctrl_wr_out, // control write strobe
    output var logic [1:0] ctrl_wdata_out // {sleep_off, chg_en}
);
    // quiet values from time zero
    initial begin
        sleep_exec_out = 1'h0;
        permit_out = 1'h0;
        mode_out = 3'h0;
        ctrl_wr_out = 1'h0;
        ctrl_wdata_out = 2'h0;
    end
    // permit and code settle a full cycle before the instruction
    task automatic sleep_instr(input logic [2:0] m, input logic p);
        @(negedge clk_in);
        permit_out = p;
        mode_out = m;
        @(negedge clk_in);
        sleep_exec_out = 1'h1;
        @(negedge clk_in);
        sleep_exec_out = 1'h0;
    endtask : sleep_instr
    // one write; data flips after the strobe so stale data never looks held
    task automatic write_ctrl(input logic [1:0] d);
        @(negedge clk_in);
        ctrl_wr_out = 1'h1;
        ctrl_wdata_out = d;
        @(negedge clk_in);
        ctrl_wr_out = 1'h0;
        ctrl_wdata_out = ~d;
    endtask : write_ctrl
    // timed sequence: open the window, then store inside it
    task automatic set_sleep_off(input logic v);
        write_ctrl(2'h3);
        write_ctrl({v, 1'h0});
    endtask : set_sleep_off
endmodule : smc_core_model
`default_nettype wire

// [smc_sleep_ctrl_tb.sv]
// self-checking bench for the sleep-mode controller
// assumes short start-up counts: 10 restart, 20 detector settle
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_ctrl_tb;
    logic clk = 1'h0, rst_n = 1'h0, irq = 1'h0, pinc = 1'h0, two_wire_port = 1'h0;
    logic ovf = 1'h0, g_en = 1'h1, t2a = 1'h0, t2s = 1'h0;
    logic cen = 1'h0, cdone = 1'h0, cmp = 1'h0, atm = 1'h0, nvm = 1'h0;
    logic [1:0] ext = 2'h0, lvl = 2'h0, t2m = 2'h0;
    logic sx, pm, wr, ce, pe, pc, cc, ac, mo, to, ts, cs, de, dso, asl, sv, ig;
    logic [2:0] md;
    logic [1:0] wd;
    logic [5:0] obs;
    int cyc = 0, n_mismatch = 0, cmp_count = 0, t0, t1, t2;
    assign obs = {ig, cs, sv, de, ce, asl};
    ////////////////////////////////////////////////////////////////////
    // 4 ns clock; cycle count used for relative timing only
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    smc_core_model smc_core_model_i (.clk_in(clk), .sleep_exec_out(sx),
        .permit_out(pm), .mode_out(md), .ctrl_wr_out(wr),
        .ctrl_wdata_out(wd));
    smc_sleep_ctrl #(.STARTUP_CYCLES(10), .BOD_WAKE_CYCLES(20))
    smc_sleep_ctrl_i (.CLK_IN(clk), .RESETN_IN(rst_n), .SLEEP_EXEC_IN(sx),
        .SLEEP_ENTRY_PERMIT_IN(pm), .LOW_POWER_STATE_CHOICE_IN(md),
        .CORE_CTRL_WR_IN(wr), .CORE_CTRL_WDATA_IN(wd), .IRQ_PENDING_IN(irq),
        .EXT_IRQ_LINE_IN(ext), .EXT_IRQ_LEVEL_MODE_IN(lvl),
        .PIN_CHANGE_IRQ_IN(pinc), .TWO_WIRE_MATCH_IN(two_wire_port),
        .WATCHDOG_EVENT_IN(1'h0), .ASYNC_TIMER_IRQ_IN(atm),
        .TIMER2_OVF_IN(ovf), .TIMER2_CMP_IN(cmp), .TIMER2_IRQ_MASK_IN(t2m),
        .GLOBAL_IRQ_EN_IN(g_en), .TIMER2_ASYNC_IN(t2a), .TIMER2_SYNC_IN(t2s),
        .CONV_ENABLED_IN(cen), .CONV_DONE_IN(cdone), .NVM_READY_IN(nvm),
        .CORE_CLK_EN_OUT(ce), .PROG_MEM_CLK_EN_OUT(pe),
        .PERIPH_CLK_EN_OUT(pc), .CONV_CLK_EN_OUT(cc), .ASYNC_CLK_EN_OUT(ac),
        .MAIN_OSC_EN_OUT(mo), .TIMER_OSC_EN_OUT(to),
        .TIMER2_SYNC_CLK_EN_OUT(ts), .CONV_START_OUT(cs),
        .DETECTOR_EN_OUT(de), .DETECTOR_SLEEP_OFF_OUT(dso), .ASLEEP_OUT(asl),
        .IRQ_SERVICE_OUT(sv), .SLEEP_IGNORED_OUT(ig));
    ////////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // bounded wait for one watched output; times out into the verdict
    task automatic wait_bit(input int idx, input logic v, input int lim,
                            output int t);
        // look first: a one-cycle pulse may already stand on entry
        for (int i = 0; i < lim; i++) begin
            t = cyc;
            if (obs[idx] === v) return;
            @(negedge clk);
        end
        n_mismatch++;
        $display("MISMATCH wait on output %0d expected %0b seen timeout", idx, v);
        print_verdict();
    endtask : wait_bit
    // halt length between end of start-up and core restart
    task automatic wake_tail(input int lim, input logic irq_exp);
        wait_bit(2, 1'h1, lim, t1);
        wait_bit(1, 1'h1, 8, t2);
        chk("halt_cycles", 32'(t2 - t1), 32'd4);
        chk("irq_service", {31'h0, sv}, {31'h0, irq_exp});
    endtask : wake_tail
    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic sc_nop();
        logic [2:0] m [2] = '{3'h4, 3'h0};
        logic p [2] = '{1'h1, 1'h0};
        for (int k = 0; k < 2; k++) begin
            smc_core_model_i.sleep_instr(m[k], p[k]);
            wait_bit(5, 1'h1, 3, t0);
            chk("nop_asleep", {31'h0, asl}, 32'h0);
            chk("nop_core", {31'h0, ce}, 32'h1);
        end
    endtask : sc_nop
    task automatic sc_pdown();
        smc_core_model_i.write_ctrl(2'h2);
        repeat (2) @(negedge clk);
        chk("sleep_off_closed", {31'h0, dso}, 32'h0);
        smc_core_model_i.set_sleep_off(1'h1);
        repeat (2) @(negedge clk);
        chk("sleep_off_set", {31'h0, dso}, 32'h1);
        smc_core_model_i.sleep_instr(3'h2, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        @(negedge clk);
        chk("pd_detector", {31'h0, de}, 32'h0);
        chk("pd_clocks", {28'h0, pc, ac, mo, to}, 32'h0);
        ext = 2'h1;
        {nvm, atm, cdone} = 3'h7; // noise-only sources must not wake
        repeat (6) @(negedge clk);
        chk("edge_no_wake", {31'h0, asl}, 32'h1);
        {nvm, atm, cdone} = 3'h0;
        lvl = 2'h1;
        wait_bit(0, 1'h0, 8, t0);
        ext = 2'h0; // level gone long before start-up ends
        wait_bit(2, 1'h1, 40, t1);
        chk("pd_startup", 32'(t1 - t0), 32'd20);
        wake_tail(1, 1'h0);
    endtask : sc_pdown
    task automatic sc_idle();
        smc_core_model_i.sleep_instr(3'h0, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        chk("idle_clocks", {26'h0, ce, pe, pc, cc, ac, mo}, 32'hF);
        chk("idle_detector", {31'h0, de}, 32'h1);
        irq = 1'h1;
        wait_bit(0, 1'h0, 4, t0);
        chk("idle_periph", {31'h0, pc}, 32'h1);
        wake_tail(1, 1'h1);
        irq = 1'h0;
    endtask : sc_idle
    task automatic sc_noise();
        cen = 1'h1;
        smc_core_model_i.sleep_instr(3'h1, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        chk("conv_start", {31'h0, cs}, 32'h1);
        chk("noise_clocks", {29'h0, ce, pc, cc}, 32'h1);
        irq = 1'h1;
        repeat (6) @(negedge clk);
        chk("noise_irq_ignored", {31'h0, asl}, 32'h1);
        irq = 1'h0;
        cdone = 1'h1;
        @(negedge clk);
        cdone = 1'h0;
        wait_bit(0, 1'h0, 4, t0);
        wait_bit(1, 1'h1, 8, t2);
        chk("noise_halt", 32'(t2 - t0), 32'd4);
        cen = 1'h0;
    endtask : sc_noise
    task automatic sc_psave();
        t2a = 1'h1;
        smc_core_model_i.sleep_instr(3'h3, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        chk("ps_osc", {29'h0, to, mo, ac}, 32'h5);
        {cmp, ovf} = 2'h3;
        repeat (5) @(negedge clk);
        chk("ps_masked", {31'h0, asl}, 32'h1);
        t2m = 2'h3;
        g_en = 1'h0;
        repeat (5) @(negedge clk);
        chk("ps_global_off", {31'h0, asl}, 32'h1);
        g_en = 1'h1;
        wait_bit(0, 1'h0, 8, t0);
        {cmp, ovf} = 2'h0;
        wake_tail(40, 1'h1);
        t2a = 1'h0;
        t2s = 1'h1;
        smc_core_model_i.sleep_instr(3'h7, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        chk("xs_osc", {29'h0, mo, ts, to}, 32'h6);
        two_wire_port = 1'h1;
        wait_bit(0, 1'h0, 8, t0);
        two_wire_port = 1'h0;
        wake_tail(40, 1'h1);
        chk("xs_startup", 32'(t1 - t0), 32'd20);
    endtask : sc_psave
    // standby with the detector kept on: six start-up plus four halt
    task automatic sc_stby();
        smc_core_model_i.set_sleep_off(1'h0);
        chk("sleep_off_clear", {31'h0, dso}, 32'h0);
        smc_core_model_i.sleep_instr(3'h6, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        chk("sb_clocks", {29'h0, mo, de, ac}, 32'h6);
        pinc = 1'h1;
        wait_bit(0, 1'h0, 8, t0);
        pinc = 1'h0;
        wait_bit(1, 1'h1, 16, t2);
        chk("sb_wake", 32'(t2 - t0), 32'd10);
        chk("sb_irq", {31'h0, sv}, 32'h1);
    endtask : sc_stby
    task automatic sc_reset_asleep();
        smc_core_model_i.set_sleep_off(1'h1);
        smc_core_model_i.sleep_instr(3'h2, 1'h1);
        wait_bit(0, 1'h1, 3, t0);
        rst_n = 1'h0;
        #1;
        chk("rst_wake", {30'h0, asl, ce}, 32'h1);
        chk("rst_sleep_off", {31'h0, dso}, 32'h0);
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
    endtask : sc_reset_asleep
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        repeat (2) @(negedge clk);
        chk("rst_values", {29'h0, dso, de, ce}, 32'h3);
        sc_nop();
        sc_pdown();
        sc_idle();
        sc_noise();
        sc_psave();
        sc_stby();
        sc_reset_asleep();
        print_verdict();
    end
endmodule : smc_sleep_ctrl_tb
`default_nettype wire
